// file: sysrc_pkg.sv
// Constants, register map and state type for the system reset controller.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
package sysrc_pkg;

  localparam int CLK_MHZ = 100;

  // Minimum widths, in ns, and their cycle counts (least times round up)
  localparam int EXT_MIN_PULSE_NS = 1500;
  localparam int BOD_MIN_TIME_NS  = 2000;
  localparam int EXT_MIN_CYC = (EXT_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int BOD_MIN_CYC = (BOD_MIN_TIME_NS * CLK_MHZ + 999) / 1000;

  // Startup timeout choices; the short one is in clocks, the others in us
  localparam int TOUT_SHORT_CYC = 6;
  localparam int TOUT_MED_US    = 4100;
  localparam int TOUT_LONG_US   = 65000;

  localparam int CNT_W  = 24;
  localparam int FILT_W = 16;

  localparam logic [1:0] TSEL_SHORT = 2'h0;
  localparam logic [1:0] TSEL_MED   = 2'h1;

  localparam logic BOD_LEVEL_2V7 = 1'h0;
  localparam logic BOD_LEVEL_4V0 = 1'h1;

  // Register byte addresses
  localparam logic [7:0] ADDR_CAUSE  = 8'h00;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h08;
  localparam logic [7:0] ADDR_STATE  = 8'h0C;

  // Cause flag and interrupt event positions
  localparam int F_POR  = 0;
  localparam int F_EXT  = 1;
  localparam int F_BOD  = 2;
  localparam int F_WDT  = 3;
  localparam int F_TAP  = 4;
  localparam int F_REL  = 5;
  localparam int NFLAG  = 5;
  localparam int NEVT   = 6;

  localparam logic [NFLAG-1:0] CAUSE_RST = 5'h00;
  localparam logic [NEVT-1:0]  IRQ_RST   = 6'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_HOLD, ST_DELAY, ST_RUN} sysrc_state_e;

endpackage

// file: sysrc_sync2.sv
// Two flip-flop synchroniser for one level.
// Assumes the input is asynchronous to i_clk_sys.
`timescale 1ns/1ps
module sysrc_sync2 #(
  parameter logic RST_VAL = 1'h0
) (
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      meta <= RST_VAL;
      o_q  <= RST_VAL;
    end
    else
    begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule // sysrc_sync2

// file: sysrc_min_filter.sv
// Asserts its output only after the input has stood high for i_min_cyc + 1 clocks.
// Assumes a synchronised input; release follows the input at once.
`timescale 1ns/1ps
module sysrc_min_filter (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_srst,
  input  wire logic                       i_level,
  input  wire logic [sysrc_pkg::FILT_W-1:0] i_min_cyc,
  output logic                            o_level
);
  logic [sysrc_pkg::FILT_W-1:0] cnt;
  logic [sysrc_pkg::FILT_W-1:0] next_cnt;
  logic                         next_level;

  always_comb
  begin
    next_cnt   = cnt;
    next_level = o_level;
    if (!i_level)
    begin
      next_cnt   = '0;
      next_level = 1'h0;
    end
    else if (cnt >= i_min_cyc)
      next_level = 1'h1;
    else
      next_cnt = cnt + 1'h1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      cnt     <= '0;
      o_level <= 1'h0;
    end
    else
    begin
      cnt     <= next_cnt;
      o_level <= next_level;
    end
  end
endmodule // sysrc_min_filter

// file: sysrc_controller.sv
// System reset controller: combines five reset sources, stretches the
// internal reset with a fuse-selected delay and records reset causes.
// Assumes analog detectors and pins are asynchronous; watchdog is on i_clk_sys.
`timescale 1ns/1ps
module sysrc_controller #(
  parameter int P_TOUT_MED_CYC  = sysrc_pkg::TOUT_MED_US * sysrc_pkg::CLK_MHZ,
  parameter int P_TOUT_LONG_CYC = sysrc_pkg::TOUT_LONG_US * sysrc_pkg::CLK_MHZ
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_supply_valid,
  input  wire logic        i_ext_reset_n,
  input  wire logic        i_wdt_expired,
  input  wire logic        i_wdt_enable,
  input  wire logic        i_brownout_under,
  input  wire logic        i_tap_reset_bit,
  input  wire logic        i_brownout_enable_fuse,
  input  wire logic        i_brownout_level_fuse,
  input  wire logic [1:0]  i_startup_time_fuses,
  output logic             o_io_force_init,
  output logic             o_internal_reset,
  output logic             o_fetch_reset_vector,
  output logic             o_brownout_detector_en,
  output logic             o_brownout_threshold_sel,
  output logic             o_irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int NF = sysrc_pkg::NFLAG;
  localparam int NE = sysrc_pkg::NEVT;

  logic                        supply_ok_s;
  logic                        ext_low_s;
  logic                        bod_under_s;
  logic                        tap_s;
  logic                        wdt_en_s;
  logic                        bod_en_s;
  logic                        bod_lvl_s;
  logic [1:0]                  tsel_s;
  logic                        ext_active;
  logic                        bod_filt;
  logic                        bod_active;
  logic                        wdt_pulse;
  logic                        next_wdt_pulse;
  logic                        wdt_exp_q;
  logic                        por_q;
  logic                        ext_q;
  logic                        bod_q;
  logic                        tap_q;
  logic                        por_evt;
  logic                        ext_evt;
  logic                        bod_evt;
  logic                        tap_evt;
  logic                        any_src;
  sysrc_pkg::sysrc_state_e     state;
  sysrc_pkg::sysrc_state_e     next_state;
  logic [sysrc_pkg::CNT_W-1:0] cnt;
  logic [sysrc_pkg::CNT_W-1:0] next_cnt;
  logic [sysrc_pkg::CNT_W-1:0] tout_cyc;
  logic                        hold;
  logic                        next_hold;
  logic                        fetch;
  logic                        next_fetch;
  logic [NF-1:0]               cause;
  logic [NF-1:0]               next_cause;
  logic [NE-1:0]               irq_st;
  logic [NE-1:0]               next_irq_st;
  logic [NE-1:0]               irq_mk;
  logic [NE-1:0]               next_irq_mk;
  logic [NE-1:0]               evt;
  logic                        aw_have;
  logic                        w_have;
  logic [7:0]                  aw_addr;
  logic [31:0]                 w_data;
  logic                        w_lane0;
  logic                        do_write;
  logic                        aw_ok;
  logic                        next_aw_have;
  logic                        next_w_have;
  logic [7:0]                  next_aw_addr;
  logic [31:0]                 next_w_data;
  logic                        next_w_lane0;
  logic                        next_bvalid;
  logic [1:0]                  next_bresp;
  logic                        next_rvalid;
  logic [31:0]                 next_rdata;
  logic [1:0]                  next_rresp;
  logic                        wr_cause;
  logic                        wr_irq_st;
  logic                        wr_irq_mk;

  // Pin and detector levels cross into the clock domain
  sysrc_sync2 #(.RST_VAL(1'h0)) u_sync_por (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_d(i_supply_valid), .o_q(supply_ok_s));
  sysrc_sync2 #(.RST_VAL(1'h0)) u_sync_ext (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_d(!i_ext_reset_n), .o_q(ext_low_s));
  sysrc_sync2 #(.RST_VAL(1'h0)) u_sync_bod (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_d(i_brownout_under), .o_q(bod_under_s));
  sysrc_sync2 #(.RST_VAL(1'h0)) u_sync_tap (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_d(i_tap_reset_bit), .o_q(tap_s));
  sysrc_sync2 #(.RST_VAL(1'h0)) u_sync_wen (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_d(i_wdt_enable), .o_q(wdt_en_s));
  sysrc_sync2 #(.RST_VAL(1'h0)) u_sync_ben (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_d(i_brownout_enable_fuse), .o_q(bod_en_s));
  sysrc_sync2 #(.RST_VAL(1'h0)) u_sync_blv (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_d(i_brownout_level_fuse), .o_q(bod_lvl_s));
  sysrc_sync2 #(.RST_VAL(1'h0)) u_sync_su0 (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_d(i_startup_time_fuses[0]), .o_q(tsel_s[0]));
  sysrc_sync2 #(.RST_VAL(1'h0)) u_sync_su1 (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_d(i_startup_time_fuses[1]), .o_q(tsel_s[1]));

  // Glitch filters on the pin and on the brown-out comparator
  sysrc_min_filter u_filt_ext (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_level   (ext_low_s),
    .i_min_cyc (sysrc_pkg::FILT_W'(sysrc_pkg::EXT_MIN_CYC)),
    .o_level   (ext_active)
  );
  sysrc_min_filter u_filt_bod (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_level   (bod_under_s),
    .i_min_cyc (sysrc_pkg::FILT_W'(sysrc_pkg::BOD_MIN_CYC)),
    .o_level   (bod_filt)
  );

  assign bod_active = bod_filt && bod_en_s;
  assign o_brownout_detector_en   = bod_en_s;
  assign o_brownout_threshold_sel = bod_lvl_s ? sysrc_pkg::BOD_LEVEL_4V0
                                              : sysrc_pkg::BOD_LEVEL_2V7;

  // One-cycle watchdog pulse on the rising edge of an enabled expiry
  assign next_wdt_pulse = i_wdt_expired && !wdt_exp_q && wdt_en_s;

  assign any_src = !supply_ok_s || ext_active || bod_active || wdt_pulse || tap_s;
  assign por_evt = !supply_ok_s && por_q;
  assign ext_evt = ext_active && !ext_q;
  assign bod_evt = bod_active && !bod_q;
  assign tap_evt = tap_s && !tap_q;

  // Clockless path to the port pins and, on supply loss, to the internal reset assertion
  assign o_io_force_init  = !i_supply_valid || !i_ext_reset_n || hold
                            || i_tap_reset_bit;
  assign o_internal_reset = hold || !i_supply_valid;
  assign o_fetch_reset_vector = fetch;

  always_comb
  begin
    case (tsel_s)
      sysrc_pkg::TSEL_SHORT: tout_cyc = sysrc_pkg::CNT_W'(sysrc_pkg::TOUT_SHORT_CYC);
      sysrc_pkg::TSEL_MED:   tout_cyc = sysrc_pkg::CNT_W'(P_TOUT_MED_CYC);
      default:              tout_cyc = sysrc_pkg::CNT_W'(P_TOUT_LONG_CYC);
    endcase
  end

  // Reset sequencing
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_fetch = 1'h0;
    case (state)
      sysrc_pkg::ST_HOLD:
      begin
        if (!any_src)
        begin
          next_state = sysrc_pkg::ST_DELAY;
          next_cnt   = tout_cyc;
        end
      end
      sysrc_pkg::ST_DELAY:
      begin
        if (any_src)
          next_state = sysrc_pkg::ST_HOLD;
        else if (cnt <= sysrc_pkg::CNT_W'(1))
        begin
          next_state = sysrc_pkg::ST_RUN;
          next_fetch = 1'h1;
        end
        else
          next_cnt = cnt - 1'h1;
      end
      sysrc_pkg::ST_RUN:
      begin
        if (any_src)
          next_state = sysrc_pkg::ST_HOLD;
      end
      default:
        next_state = sysrc_pkg::ST_HOLD;
    endcase
    next_hold = (next_state != sysrc_pkg::ST_RUN);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      state     <= sysrc_pkg::ST_HOLD;
      cnt       <= '0;
      hold      <= 1'h1;
      fetch     <= 1'h0;
      wdt_pulse <= 1'h0;
      wdt_exp_q <= 1'h0;
      por_q     <= 1'h1;
      ext_q     <= 1'h0;
      bod_q     <= 1'h0;
      tap_q     <= 1'h0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      hold      <= next_hold;
      fetch     <= next_fetch;
      wdt_pulse <= next_wdt_pulse;
      wdt_exp_q <= i_wdt_expired;
      por_q     <= supply_ok_s;
      ext_q     <= ext_active;
      bod_q     <= bod_active;
      tap_q     <= tap_s;
    end
  end

  // Cause flags, interrupts and bus slave
  assign aw_ok     = aw_have && w_have;
  assign do_write  = aw_ok && !s_axi_bvalid;
  assign wr_cause  = do_write && w_lane0 && (aw_addr == sysrc_pkg::ADDR_CAUSE);
  assign wr_irq_st = do_write && w_lane0 && (aw_addr == sysrc_pkg::ADDR_IRQ_ST);
  assign wr_irq_mk = do_write && w_lane0 && (aw_addr == sysrc_pkg::ADDR_IRQ_MK);
  assign evt = {fetch, tap_evt, wdt_pulse, bod_evt, ext_evt, por_evt};
  assign s_axi_awready = !aw_have;
  assign s_axi_wready  = !w_have;
  assign s_axi_arready = !s_axi_rvalid;
  assign o_irq = |(irq_st & irq_mk);

  always_comb
  begin
    next_cause = cause;
    if (wr_cause)
      next_cause = cause & w_data[NF-1:0];
    if (por_evt)
      next_cause[sysrc_pkg::F_WDT:sysrc_pkg::F_EXT] = '0;
    if (bod_evt)
      next_cause[sysrc_pkg::F_TAP] = 1'h0;
    if (por_evt)
      next_cause[sysrc_pkg::F_POR] = 1'h1;
    if (ext_evt)
      next_cause[sysrc_pkg::F_EXT] = 1'h1;
    if (bod_evt)
      next_cause[sysrc_pkg::F_BOD] = 1'h1;
    if (wdt_pulse)
      next_cause[sysrc_pkg::F_WDT] = 1'h1;
    if (tap_evt)
      next_cause[sysrc_pkg::F_TAP] = 1'h1;
    next_irq_st = (wr_irq_st ? (irq_st & ~w_data[NE-1:0]) : irq_st) | evt;
    next_irq_mk = wr_irq_mk ? w_data[NE-1:0] : irq_mk;
  end

  always_comb
  begin
    next_aw_have = aw_have;
    next_aw_addr = aw_addr;
    next_w_have  = w_have;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_have = 1'h1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_have  = 1'h1;
      next_w_data  = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      next_aw_have = 1'h0;
      next_w_have  = 1'h0;
      next_bvalid  = 1'h1;
      next_bresp   = (aw_addr == sysrc_pkg::ADDR_CAUSE || aw_addr == sysrc_pkg::ADDR_IRQ_ST
                     || aw_addr == sysrc_pkg::ADDR_IRQ_MK || aw_addr == sysrc_pkg::ADDR_STATE)
                     ? sysrc_pkg::RESP_OKAY : sysrc_pkg::RESP_SLVERR;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'h1;
      next_rresp  = sysrc_pkg::RESP_OKAY;
      next_rdata  = '0;
      case (s_axi_araddr)
        sysrc_pkg::ADDR_CAUSE:  next_rdata[NF-1:0] = cause;
        sysrc_pkg::ADDR_IRQ_ST: next_rdata[NE-1:0] = irq_st;
        sysrc_pkg::ADDR_IRQ_MK: next_rdata[NE-1:0] = irq_mk;
        sysrc_pkg::ADDR_STATE:  next_rdata[7:0] = {bod_lvl_s, bod_en_s, tsel_s,
                                                   1'h0, any_src, hold, fetch};
        default:                next_rresp = sysrc_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      cause        <= sysrc_pkg::CAUSE_RST;
      irq_st       <= sysrc_pkg::IRQ_RST;
      irq_mk       <= sysrc_pkg::IRQ_RST;
      aw_have      <= 1'h0;
      aw_addr      <= '0;
      w_have       <= 1'h0;
      w_data       <= '0;
      w_lane0      <= 1'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp  <= sysrc_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= sysrc_pkg::RESP_OKAY;
    end
    else
    begin
      cause        <= next_cause;
      irq_st       <= next_irq_st;
      irq_mk       <= next_irq_mk;
      aw_have      <= next_aw_have;
      aw_addr      <= next_aw_addr;
      w_have       <= next_w_have;
      w_data       <= next_w_data;
      w_lane0      <= next_w_lane0;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  chk_wdt_one_cycle: assert property (wdt_pulse |=> !wdt_pulse)
    else $error("watchdog pulse longer than one cycle");
  chk_wdt_enable_gate: assert property (wdt_pulse |-> $past(wdt_en_s))
    else $error("watchdog reset while disabled");
  chk_tap_hold_reset: assert property (tap_s |=> o_internal_reset)
    else $error("test-port bit did not hold reset");
  chk_bod_fuse_gate: assert property ($rose(cause[sysrc_pkg::F_BOD]) |-> $past(bod_en_s))
    else $error("brown-out reset with fuse unprogrammed");
  chk_release_delay: assert property ($fell(hold) |-> $past(state) == sysrc_pkg::ST_DELAY
    && $past(cnt) <= sysrc_pkg::CNT_W'(1))
    else $error("reset released before delay expired");
  chk_fetch_on_release: assert property ($fell(hold) |-> fetch ##1 !fetch)
    else $error("no single fetch pulse at release");
  chk_por_flag_set: assert property (por_evt |=> cause[sysrc_pkg::F_POR]
    && !cause[sysrc_pkg::F_WDT])
    else $error("power-on flags wrong");
  chk_ext_flag_set: assert property (ext_evt |=> cause[sysrc_pkg::F_EXT])
    else $error("pin reset flag not set");
  chk_delay_restart: assert property (state == sysrc_pkg::ST_DELAY && any_src
    |=> state == sysrc_pkg::ST_HOLD ##1 hold)
    else $error("delay not restarted by new source");

  cov_wdt_reset: cover property (wdt_pulse ##1 state == sysrc_pkg::ST_DELAY);
  cov_bod_reset: cover property (bod_evt ##[1:20] state == sysrc_pkg::ST_HOLD);
  cov_release:   cover property ($fell(hold));
endmodule // sysrc_controller

// file: sysrc_src_model.sv
// Reset requester model: supply detector, pin, watchdog, brown-out, test bit.
// Assumes the bench starts one request at a time, held for i_len clocks.
`timescale 1ns/1ps
module sysrc_src_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_go,
  input  wire logic [2:0]  i_sel,
  input  wire logic [15:0] i_len,
  output logic             o_supply_valid,
  output logic             o_ext_reset_n,
  output logic             o_wdt_expired,
  output logic             o_brownout_under,
  output logic             o_tap_reset_bit
);
  logic [15:0] cnt = 16'h0000;
  logic [2:0]  sel = 3'h0;
  logic        act;
  always @(posedge i_clk_sys)
  begin
    if (i_go)
    begin
      cnt <= i_len;
      sel <= i_sel;
    end
    else if (act)
      cnt <= cnt - 16'h0001;
  end
  assign act              = (cnt != 16'h0000);
  assign o_supply_valid   = !(act && sel == 3'h0);
  assign o_ext_reset_n    = !(act && sel == 3'h1);
  assign o_wdt_expired    = act && sel == 3'h2;
  assign o_brownout_under = act && sel == 3'h3;
  assign o_tap_reset_bit  = act && sel == 3'h4;
endmodule // sysrc_src_model

// file: system_reset_controller_tb_top.sv
// Self-checking bench for the reset controller, registers over AXI4-Lite.
// Assumes the requester model drives all five reset sources.
`timescale 1ns/1ps
module system_reset_controller_tb_top;
  logic        clk = 1'h0, srst = 1'h1, go = 1'h0, wen = 1'h0, bfe = 1'h0, blf = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        sv, extn, wdx, bu, tap, iof, irst, fetch, bde, bts, irq;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  tsel = 2'h0;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  sel = 3'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [15:0] len = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  int          bad_count = 0, cmp_count = 0, cyc = 0, n, t;

  sysrc_src_model u_src (.i_clk_sys(clk), .i_go(go), .i_sel(sel), .i_len(len),
    .o_supply_valid(sv), .o_ext_reset_n(extn), .o_wdt_expired(wdx),
    .o_brownout_under(bu), .o_tap_reset_bit(tap));
  sysrc_controller #(.P_TOUT_MED_CYC(20), .P_TOUT_LONG_CYC(40)) u_dut (
    .i_clk_sys(clk), .i_srst(srst), .i_supply_valid(sv), .i_ext_reset_n(extn),
    .i_wdt_expired(wdx), .i_wdt_enable(wen), .i_brownout_under(bu),
    .i_tap_reset_bit(tap), .i_brownout_enable_fuse(bfe), .i_brownout_level_fuse(blf),
    .i_startup_time_fuses(tsel), .o_io_force_init(iof), .o_internal_reset(irst),
    .o_fetch_reset_vector(fetch), .o_brownout_detector_en(bde),
    .o_brownout_threshold_sel(bts), .o_irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    cmp_count++;
    if (v !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, v, e);
    end
  endtask

  task automatic end_of_test();
    $display("TB: compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Address and data offered together, each released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_p;
    logic w_p;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    aw_p = 1'h1;
    w_p = 1'h1;
    while (aw_p || w_p)
    begin
      @(negedge clk);
      aw_p = aw_p && !awready;
      w_p = w_p && !wready;
      @(posedge clk);
      awvalid <= aw_p;
      wvalid <= w_p;
    end
    while (!bvalid) @(negedge clk);
    resp = bresp;
    @(posedge clk);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'h0;
    while (!rvalid) @(negedge clk);
    rd_v = rdata;
    resp = rresp;
    @(posedge clk);
    rready <= 1'h0;
  endtask

  task automatic src(input logic [2:0] s, input int l, input int w);
    @(posedge clk);
    sel <= s;
    len <= l[15:0];
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (w) @(posedge clk);
  endtask

  // Counts reset cycles up to release, then checks the one-cycle fetch pulse
  task automatic rel();
    @(negedge clk);
    n = 0;
    while (irst)
    begin
      @(negedge clk);
      n++;
    end
    chk(fetch, 1);
    @(negedge clk);
    chk(fetch, 0);
  endtask

  task automatic cause(input logic [31:0] e);
    rd(8'h00);
    chk(rd_v, e);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t timeout", $time);
      end_of_test();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rel();
    chk(32'(n >= 6 && n <= 12), 1);
    cause(32'h01);
    wr(8'h00, 32'h0);
    chk(resp, 0);
    cause(32'h00);
    wr(8'h04, 32'h3F);
    wr(8'h08, 32'h02);
    $display("test power-up done");
    src(3'h1, 50, 5);
    chk(iof, 1);
    chk(irst, 0);
    repeat (60) @(posedge clk);
    cause(32'h00);
    chk(irq, 0);
    src(3'h1, 200, 200);
    chk(irst, 1);
    rel();
    cause(32'h02);
    chk(irq, 1);
    wr(8'h04, 32'h02);
    chk(irq, 0);
    $display("test pin done");
    src(3'h2, 1, 10);
    chk(irst, 0);
    wen <= 1'h1;
    src(3'h2, 1, 3);
    chk(irst, 1);
    rel();
    cause(32'h0A);
    $display("test watchdog done");
    for (int f = 0; f < 3; f++)
    begin
      @(posedge clk);
      tsel <= f[1:0];
      t = (f == 0) ? 6 : (f == 1) ? 20 : 40;
      src(3'h4, 100, 5);
      chk(irst, 1);
      rel();
      chk(32'(n >= t + 92 && n <= t + 102), 1);
    end
    // A new request during the long delay must restart the full count
    src(3'h4, 5, 20);
    src(3'h4, 5, 5);
    rel();
    chk(32'(n >= 40 && n <= 46), 1);
    cause(32'h1A);
    $display("test test-port done");
    src(3'h3, 300, 310);
    chk(irst, 0);
    bfe <= 1'h1;
    blf <= 1'h1;
    repeat (5) @(posedge clk);
    chk(bde, 1);
    chk(bts, 1);
    blf <= 1'h0;
    repeat (5) @(posedge clk);
    chk(bts, 0);
    src(3'h3, 100, 110);
    chk(irst, 0);
    src(3'h3, 300, 300);
    chk(irst, 1);
    rel();
    cause(32'h0E);
    $display("test brown-out done");
    src(3'h0, 10, 1);
    chk(irst, 1);
    rel();
    cause(32'h01);
    rd(8'h10);
    chk(resp, 2);
    chk(rd_v, 0);
    wr(8'h10, 32'h1F);
    chk(resp, 2);
    rd(8'h0C);
    chk(rd_v, 32'h60);
    $display("test supply drop done");
    end_of_test();
  end
endmodule // system_reset_controller_tb_top
